// ---- hdl/pulse_input_conditioner.sv ----
// digital input conditioner with AXI4-Lite registers and event routing
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pulse_input_conditioner
	import pic_pkg::*;
(
	input  wire logic                  clk,            // 40 MHz system clock
	input  wire logic                  arst_n,         // async reset, active low
	input  wire logic [NUM_INPUTS-1:0] contactIn,      // raw contacts, 1 = closed
	input  wire logic                  s_axi_awvalid,  // write address valid
	output logic                       s_axi_awready,  // write address ready
	input  wire logic [7:0]            s_axi_awaddr,   // write address
	input  wire logic                  s_axi_wvalid,   // write data valid
	output logic                       s_axi_wready,   // write data ready
	input  wire logic [31:0]           s_axi_wdata,    // write data
	input  wire logic [3:0]            s_axi_wstrb,    // byte enables
	output logic                       s_axi_bvalid,   // write response valid
	input  wire logic                  s_axi_bready,   // write response ready
	output logic [1:0]                 s_axi_bresp,    // write response
	input  wire logic                  s_axi_arvalid,  // read address valid
	output logic                       s_axi_arready,  // read address ready
	input  wire logic [7:0]            s_axi_araddr,   // read address
	output logic                       s_axi_rvalid,   // read data valid
	input  wire logic                  s_axi_rready,   // read data ready
	output logic [31:0]                s_axi_rdata,    // read data
	output logic [1:0]                 s_axi_rresp,    // read response
	output logic [NUM_INPUTS-1:0]      setpointEvent,  // status-change strobes
	output logic [NUM_INPUTS-1:0]      billingPulse,   // billing/time-of-use strobes
	output logic                       irq             // level interrupt
);
	logic [NUM_INPUTS-1:0] transitionMode, polarity, level, strobe;
	logic [NUM_INPUTS-1:0] status, enable;
	logic [6:0]            debounceMs;
	logic [2*NUM_INPUTS-1:0] route;
	logic [31:0]           counter [NUM_INPUTS];
	logic [15:0]           msCount;
	logic                  msTick;

	// millisecond tick divider
	logic [15:0] next_msCount;
	logic        next_msTick;
	always_comb begin
		next_msTick  = 1'b0;
		next_msCount = msCount + 16'h0001;
		if (msCount == 16'(MS_CYCLES - 1)) begin
			next_msCount = 16'h0000;
			next_msTick  = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			msCount <= 16'h0000;
			msTick  <= 1'b0;
		end else begin
			msCount <= next_msCount;
			msTick  <= next_msTick;
		end
	end

	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
		input_debouncer u_deb (
			.clk            (clk),
			.arst_n         (arst_n),
			.rawIn          (contactIn[i]),
			.msTick         (msTick),
			.debounceMs     (debounceMs),
			.transitionMode (transitionMode[i]),
			.invert         (polarity[i]),
			.level          (level[i]),
			.eventStrobe    (strobe[i])
		);
	end

	function automatic logic [1:0] routeOf(input logic [2*NUM_INPUTS-1:0] r, input int idx);
		routeOf = r[2*idx +: 2];
	endfunction : routeOf

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			if (be[b]) old[8*b +: 8] = d[8*b +: 8];
		end
		mergeBytes = old;
	endfunction : mergeBytes

	// write channel: address and data taken in either order
	logic        awHeld, wHeld, next_awHeld, next_wHeld;
	logic [7:0]  awAddr, next_awAddr;
	logic [31:0] wData, next_wData;
	logic [3:0]  wStrb, next_wStrb;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        doWrite;
	logic [31:0] merged;
	always_comb begin
		next_awHeld = awHeld;
		next_wHeld  = wHeld;
		next_awAddr = awAddr;
		next_wData  = wData;
		next_wStrb  = wStrb;
		next_bvalid = s_axi_bvalid;
		next_bresp  = s_axi_bresp;
		doWrite     = 1'b0;
		merged      = 32'h00000000;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (awHeld && wHeld && !s_axi_bvalid) begin
			doWrite     = 1'b1;
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = RESP_OKAY;
			case (awAddr)
				OFF_MODE, OFF_POLARITY, OFF_DEBOUNCE, OFF_ROUTE,
				OFF_CLEAR, OFF_ENABLE: next_bresp = RESP_OKAY;
				default:               next_bresp = RESP_SLVERR;
			endcase
		end
		case (awAddr)
			OFF_MODE:     merged = mergeBytes(32'(transitionMode), wData, wStrb);
			OFF_POLARITY: merged = mergeBytes(32'(polarity), wData, wStrb);
			OFF_DEBOUNCE: merged = mergeBytes(32'(debounceMs), wData, wStrb);
			OFF_ROUTE:    merged = mergeBytes(32'(route), wData, wStrb);
			OFF_ENABLE:   merged = mergeBytes(32'(enable), wData, wStrb);
			OFF_CLEAR:    merged = mergeBytes(32'h00000000, wData, wStrb);
			default:      merged = 32'h00000000;
		endcase
	end

	// configuration, status and counters
	logic [NUM_INPUTS-1:0]   next_mode, next_pol, next_status, next_enable;
	logic [6:0]              next_debounce;
	logic [2*NUM_INPUTS-1:0] next_route;
	logic [31:0]             next_counter [NUM_INPUTS];
	logic [NUM_INPUTS-1:0]   next_setpoint, next_billing;
	always_comb begin
		next_mode     = transitionMode;
		next_pol      = polarity;
		next_debounce = debounceMs;
		next_route    = route;
		next_enable   = enable;
		next_status   = status;
		next_setpoint = '0;
		next_billing  = '0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			next_counter[i] = counter[i];
		end
		if (doWrite) begin
			case (awAddr)
				OFF_MODE:     next_mode   = merged[NUM_INPUTS-1:0];
				OFF_POLARITY: next_pol    = merged[NUM_INPUTS-1:0];
				OFF_ROUTE:    next_route  = merged[2*NUM_INPUTS-1:0];
				OFF_ENABLE:   next_enable = merged[NUM_INPUTS-1:0];
				OFF_CLEAR:    next_status = status & ~merged[NUM_INPUTS-1:0];
				OFF_DEBOUNCE: begin
					// out-of-range values are clamped, never zero
					if (merged[6:0] < DEBOUNCE_MIN || merged[31:7] != '0) begin
						next_debounce = (merged[31:7] != '0) ? DEBOUNCE_MAX : DEBOUNCE_MIN;
					end else if (merged[6:0] > DEBOUNCE_MAX) begin
						next_debounce = DEBOUNCE_MAX;
					end else begin
						next_debounce = merged[6:0];
					end
				end
				default: next_mode = transitionMode;
			endcase
		end
		// set wins over a same-cycle clear
		next_status = next_status | strobe;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (strobe[i]) begin
				case (routeOf(route, i))
					ROUTE_SETPOINT: next_setpoint[i] = 1'b1;
					ROUTE_COUNTER:  next_counter[i]  = counter[i] + 32'h00000001;
					ROUTE_BILLING:  next_billing[i]  = 1'b1;
					default:        next_setpoint[i] = 1'b0;
				endcase
			end
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			transitionMode <= '0;
			polarity       <= '0;
			debounceMs     <= DEBOUNCE_RST;
			route          <= '0;
			enable         <= '0;
			status         <= '0;
			setpointEvent  <= '0;
			billingPulse   <= '0;
			irq            <= 1'b0;
			awHeld         <= 1'b0;
			wHeld          <= 1'b0;
			awAddr         <= 8'h00;
			wData          <= 32'h00000000;
			wStrb          <= 4'h0;
			s_axi_bvalid   <= 1'b0;
			s_axi_bresp    <= RESP_OKAY;
			for (int i = 0; i < NUM_INPUTS; i++) counter[i] <= 32'h00000000;
		end else begin
			transitionMode <= next_mode;
			polarity       <= next_pol;
			debounceMs     <= next_debounce;
			route          <= next_route;
			enable         <= next_enable;
			status         <= next_status;
			setpointEvent  <= next_setpoint;
			billingPulse   <= next_billing;
			irq            <= |(next_status & next_enable);
			awHeld         <= next_awHeld;
			wHeld          <= next_wHeld;
			awAddr         <= next_awAddr;
			wData          <= next_wData;
			wStrb          <= next_wStrb;
			s_axi_bvalid   <= next_bvalid;
			s_axi_bresp    <= next_bresp;
			for (int i = 0; i < NUM_INPUTS; i++) counter[i] <= next_counter[i];
		end
	end

	// ready while nothing of that channel is held
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !next_awHeld && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !next_wHeld && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// read channel
	rdState_t    rdState, next_rdState;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        next_arready;
	always_comb begin
		next_rdState = rdState;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		next_arready = s_axi_arready;
		case (rdState)
			IDLE: begin
				next_arready = 1'b1;
				if (s_axi_arvalid && s_axi_arready) begin
					next_arready = 1'b0;
					next_rdState = WAITING;
					next_rresp   = RESP_OKAY;
					next_rdata   = 32'h00000000;
					case (s_axi_araddr)
						OFF_MODE:     next_rdata = 32'(transitionMode);
						OFF_POLARITY: next_rdata = 32'(polarity);
						OFF_DEBOUNCE: next_rdata = 32'(debounceMs);
						OFF_ROUTE:    next_rdata = 32'(route);
						OFF_LEVEL:    next_rdata = 32'(level);
						OFF_STATUS:   next_rdata = 32'(status);
						OFF_ENABLE:   next_rdata = 32'(enable);
						OFF_CLEAR:    next_rdata = 32'h00000000;
						default: begin
							if (s_axi_araddr >= OFF_COUNT0 &&
								s_axi_araddr < OFF_COUNT0 + 8'(4 * NUM_INPUTS) &&
								s_axi_araddr[1:0] == 2'h0) begin
								next_rdata = counter[2'(s_axi_araddr[7:2] - OFF_COUNT0[7:2])];
							end else begin
								next_rresp = RESP_SLVERR;
							end
						end
					endcase
				end
			end
			WAITING: begin
				if (s_axi_rready) begin
					next_rdState = IDLE;
					next_arready = 1'b1;
				end
			end
			default: next_rdState = IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdState       <= IDLE;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
		end else begin
			rdState       <= next_rdState;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= (next_rdState == WAITING);
		end
	end
endmodule : pulse_input_conditioner
`default_nettype wire

// ---- hdl/pic_pkg.sv ----
// constants and types for the pulse input conditioner
// Functional notes
// - single-edge mode (default) turns exactly one transition per pulse into an event.
// - transition mode reports every debounced rise and fall as separate events.
// - normal polarity (default) counts the open-to-closed change as the event.
// - inverting polarity counts the closed-to-open change as the event.
// - polarity is ignored while transition mode is selected.
// - new level accepted only after stable for debounce time, 1-100 ms, default 10.
// - one debounce time shared by all inputs; writing it updates every input.
// - events route to setpoint status indications or to a general pulse counter.
// - events may also route to billing and time-of-use accumulators.
package pic_pkg;
	localparam int          NUM_INPUTS    = 4;
	localparam int          CLK_HZ        = 40000000;
	localparam int          TICK_MS       = 1;
	localparam int          MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam logic [6:0]  DEBOUNCE_MIN  = 7'h01;
	localparam logic [6:0]  DEBOUNCE_MAX  = 7'h64;
	localparam logic [6:0]  DEBOUNCE_RST  = 7'h0A;
	// register byte offsets
	localparam logic [7:0]  OFF_MODE      = 8'h00;
	localparam logic [7:0]  OFF_POLARITY  = 8'h04;
	localparam logic [7:0]  OFF_DEBOUNCE  = 8'h08;
	localparam logic [7:0]  OFF_ROUTE     = 8'h0C;
	localparam logic [7:0]  OFF_LEVEL     = 8'h10;
	localparam logic [7:0]  OFF_STATUS    = 8'h14;
	localparam logic [7:0]  OFF_CLEAR     = 8'h18;
	localparam logic [7:0]  OFF_ENABLE    = 8'h1C;
	localparam logic [7:0]  OFF_COUNT0    = 8'h20;
	localparam logic [1:0]  ROUTE_SETPOINT = 2'h0;
	localparam logic [1:0]  ROUTE_COUNTER  = 2'h1;
	localparam logic [1:0]  ROUTE_BILLING  = 2'h2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [1:0] {IDLE, WAITING} rdState_t;
endpackage : pic_pkg

// ---- hdl/input_debouncer.sv ----
// one input: synchroniser, debounce timer and edge strobes
`timescale 1ns/100ps
`default_nettype none
module input_debouncer
	import pic_pkg::*;
(
	input  wire logic       clk,          // system clock
	input  wire logic       arst_n,       // async reset, active low
	input  wire logic       rawIn,        // contact level, 1 = closed
	input  wire logic       msTick,       // one-cycle millisecond enable
	input  wire logic [6:0] debounceMs,   // shared debounce time
	input  wire logic       transitionMode, // both edges count
	input  wire logic       invert,       // closed-to-open counts
	output logic            level,        // debounced level
	output logic            eventStrobe   // one-cycle event
);
	logic       sync1, sync2, next_level, next_event;
	logic [6:0] stableMs, next_stableMs;

	always_comb begin
		next_level    = level;
		next_event    = 1'b0;
		next_stableMs = stableMs;
		if (sync2 == level) begin
			next_stableMs = 7'h00;
		end else if (msTick) begin
			// the first tick after a change can follow it at once, so wait one tick more
			if (stableMs >= debounceMs) begin
				next_level    = sync2;
				next_stableMs = 7'h00;
				if (transitionMode) begin
					next_event = 1'b1;
				end else begin
					next_event = sync2 ^ invert;
				end
			end else begin
				next_stableMs = stableMs + 7'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1       <= 1'b0;
			sync2       <= 1'b0;
			level       <= 1'b0;
			eventStrobe <= 1'b0;
			stableMs    <= 7'h00;
		end else begin
			sync1       <= rawIn;
			sync2       <= sync1;
			level       <= next_level;
			eventStrobe <= next_event;
			stableMs    <= next_stableMs;
		end
	end
endmodule : input_debouncer
`default_nettype wire

// ---- bench/pic_monitor.sv ----
// assertions watching the pulse input conditioner ports
`timescale 1ns/100ps
`default_nettype none
module pic_monitor
	import pic_pkg::*;
(
	input wire logic                  clk,           // clock
	input wire logic                  arst_n,        // reset
	input wire logic [NUM_INPUTS-1:0] contactIn,     // contacts
	input wire logic                  s_axi_awvalid, // aw valid
	input wire logic                  s_axi_awready, // aw ready
	input wire logic                  s_axi_wvalid,  // w valid
	input wire logic                  s_axi_wready,  // w ready
	input wire logic                  s_axi_bvalid,  // b valid
	input wire logic                  s_axi_bready,  // b ready
	input wire logic [1:0]            s_axi_bresp,   // b resp
	input wire logic                  s_axi_arvalid, // ar valid
	input wire logic                  s_axi_arready, // ar ready
	input wire logic                  s_axi_rvalid,  // r valid
	input wire logic                  s_axi_rready,  // r ready
	input wire logic [31:0]           s_axi_rdata,   // r data
	input wire logic [1:0]            s_axi_rresp,   // r resp
	input wire logic [NUM_INPUTS-1:0] setpointEvent, // setpoint strobes
	input wire logic [NUM_INPUTS-1:0] billingPulse   // billing strobes
);
	logic [NUM_INPUTS-1:0] lastIn;
	logic [NUM_INPUTS-1:0] tooSoon;
	logic [15:0]           since [NUM_INPUTS];
	// cycles each raw contact has been steady; saturates, only compared to one ms
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lastIn <= '0;
			for (int i = 0; i < NUM_INPUTS; i++) since[i] <= 16'h0;
		end else begin
			lastIn <= contactIn;
			for (int i = 0; i < NUM_INPUTS; i++)
				since[i] <= (contactIn[i] != lastIn[i]) ? 16'h0 :
					(since[i] == 16'hFFFF) ? since[i] : since[i] + 16'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++)
			tooSoon[i] = (setpointEvent[i] | billingPulse[i]) && (since[i] < 16'(MS_CYCLES));
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_sp_one_cycle: assert property ((setpointEvent != '0) |=>
		((setpointEvent & $past(setpointEvent)) == '0)) else $error("setpoint strobe too long");
	chk_bill_one_cycle: assert property ((billingPulse != '0) |=>
		((billingPulse & $past(billingPulse)) == '0)) else $error("billing strobe too long");
	chk_route_exclusive: assert property ((setpointEvent & billingPulse) == '0)
		else $error("event on two routes");
	chk_debounce_hold: assert property (tooSoon == '0)
		else $error("event before contact was steady");
	chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
	chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule : pic_monitor
bind pulse_input_conditioner pic_monitor u_mon (
	.clk(clk), .arst_n(arst_n), .contactIn(contactIn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.setpointEvent(setpointEvent), .billingPulse(billingPulse)
);
`default_nettype wire

// ---- bench/contact_model.sv ----
// bouncing dry contacts driving the raw inputs
`timescale 1ns/100ps
`default_nettype none
module contact_model
	import pic_pkg::*;
(
	input  wire logic                  clk,     // system clock
	output logic      [NUM_INPUTS-1:0] contacts // 1 = closed, open reads 0
);
	initial contacts = '0;
	// a few random chatter bursts, each far shorter than one ms, then settle
	task automatic move(input logic [NUM_INPUTS-1:0] target);
		int n;
		n = 2 + $urandom % 4;
		repeat (n) begin
			@(posedge clk);
			contacts <= target;
			repeat (1 + $urandom % 300) @(posedge clk);
			contacts <= ~target;
			repeat (1 + $urandom % 300) @(posedge clk);
		end
		contacts <= target;
	endtask : move
endmodule : contact_model
`default_nettype wire

// ---- bench/tb_pulse_input_conditioner.sv ----
// self-checking bench for the pulse input conditioner
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin badCount++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_pulse_input_conditioner
	import pic_pkg::*;
;
	logic                  clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic                  s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic                  s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [7:0]            s_axi_awaddr, s_axi_araddr, s;
	logic [31:0]           s_axi_wdata, s_axi_rdata, r;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic [NUM_INPUTS-1:0] contactIn, setpointEvent, billingPulse;
	logic [34:0]           e;
	logic [1:0]            bq [$];
	logic [34:0]           rq [$];
	logic [7:0]            sq [$];
	int                    badCount = 0, totalChecks = 0, cycles = 0;
	pulse_input_conditioner uut (.clk(clk), .arst_n(arst_n), .contactIn(contactIn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .setpointEvent(setpointEvent),
		.billingPulse(billingPulse), .irq(irq));
	contact_model partner (.clk(clk), .contacts(contactIn));
	always #12.5 clk = ~clk;
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : reportAndStop
	always @(posedge clk) begin
		cycles++;
		// each 1 ms debounce needs up to two ticks of 40000 cycles, plus chatter
		if (cycles == 180000) begin
			badCount++;
			reportAndStop();
		end
	end
	// results are taken in the order the driver noted them
	always @(posedge clk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			e = {1'b0, bq.pop_front(), 32'h0};
			`CHECK(s_axi_bresp, e[33:32])
		end
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			`CHECK(s_axi_rresp, e[33:32])
			if (e[34]) `CHECK(s_axi_rdata, e[31:0])
		end
		if ((setpointEvent | billingPulse) != '0) begin
			s = (sq.size() != 0) ? sq.pop_front() : 8'h00;
			`CHECK({setpointEvent, billingPulse}, s)
		end
	end
	function automatic logic [34:0] ok(input logic [31:0] d);
		return {3'h4, d};
	endfunction : ok
	// response ready raised late on purpose so the slave must hold its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		bq.push_back(rsp);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) w = 1'b0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		repeat (3) @(posedge clk);
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [34:0] x);
		rq.push_back(x);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		repeat (2) @(posedge clk);
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic waitEvents();
		int n;
		n = 0;
		while (sq.size() != 0 && n < 100000) begin
			@(posedge clk);
			n++;
		end
		`CHECK(sq.size(), 0)
		repeat (4) @(posedge clk);
	endtask : waitEvents
	initial begin
		{clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		r = $urandom(32'h4918f886);
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(OFF_MODE, ok(32'h0));
		rd(OFF_POLARITY, ok(32'h0));
		rd(OFF_DEBOUNCE, ok(32'hA));
		rd(OFF_ROUTE, ok(32'h0));
		rd(OFF_ENABLE, ok(32'h0));
		rd(8'h30, {3'h2, 32'h0});
		wr(8'h30, 32'h1, RESP_SLVERR);
		wr(OFF_DEBOUNCE, 32'h0, RESP_OKAY);
		rd(OFF_DEBOUNCE, ok(32'h1));
		wr(OFF_DEBOUNCE, 32'h7F, RESP_OKAY);
		rd(OFF_DEBOUNCE, ok(32'h64));
		r = 32'h1 + 32'($urandom % 100);
		wr(OFF_DEBOUNCE, r, RESP_OKAY);
		rd(OFF_DEBOUNCE, ok(r));
		wr(OFF_DEBOUNCE, 32'h1, RESP_OKAY);
		wr(OFF_MODE, 32'hC, RESP_OKAY);
		wr(OFF_POLARITY, 32'hA, RESP_OKAY);
		wr(OFF_ROUTE, 32'h24, RESP_OKAY);
		sq.push_back(8'h94);
		partner.move(4'hF);
		rd(OFF_LEVEL, ok(32'h0));
		waitEvents();
		rd(OFF_LEVEL, ok(32'hF));
		rd(OFF_STATUS, ok(32'hD));
		`CHECK(irq, 1'b0)
		wr(OFF_ENABLE, 32'hF, RESP_OKAY);
		repeat (3) @(posedge clk);
		`CHECK(irq, 1'b1)
		wr(OFF_CLEAR, 32'hD, RESP_OKAY);
		rd(OFF_STATUS, ok(32'h0));
		`CHECK(irq, 1'b0)
		sq.push_back(8'h84);
		partner.move(4'h0);
		waitEvents();
		rd(OFF_STATUS, ok(32'hE));
		`CHECK(irq, 1'b1)
		rd(OFF_COUNT0 + 8'h4, ok(32'h1));
		rd(OFF_COUNT0, ok(32'h0));
		reportAndStop();
	end
endmodule : tb_pulse_input_conditioner
`default_nettype wire
